// >>> verilog/scl_pkg.sv
// Shared constants and carrier types for the strap, clock and indicator block.
// Assumes a single 20 MHz system clock; all pins are handled as plain signals.
`default_nettype none
package scl_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ = 20_000_000;
  // Indicator blink half period in milliseconds and as clock cycles
  localparam int unsigned BLINK_TIME_MS = 50;
  localparam int unsigned BLINK_CYCLES_DEFAULT = CLK_HZ / 1000 * BLINK_TIME_MS;
  localparam int BLINK_W = 20;
  // Cycles the strap synchronisers need before a sample is trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  // Strap values held until the first capture
  localparam logic SEL_STRAP_RESET = 1'b1;
  localparam logic REG_STRAP_RESET = 1'b0;
  // Reference clock half period measurement
  localparam int HALF_W = 6;
  localparam logic [HALF_W-1:0] HALF_MAX = 6'h3F;
  localparam logic [HALF_W-1:0] HALF_MIN = 6'h02;
  // Receive elasticity buffer
  localparam int EB_AW = 3;
  localparam int EB_DEPTH = 8;
  localparam logic [EB_AW:0] EB_START_FILL = 4'h4;

  typedef enum logic [1:0] {
    SCL_ST_RESET = 2'h0,
    SCL_ST_SAMPLE = 2'h1,
    SCL_ST_RUN = 2'h3
  } scl_state_t;

  typedef struct packed {
    logic en;
    logic [1:0] data;
  } scl_tx_t;

  typedef struct packed {
    logic dv;
    logic er;
    logic [1:0] data;
  } scl_rx_t;
endpackage : scl_pkg
`default_nettype wire

// >>> verilog/scl_elastic_buf.sv
// Receive elasticity buffer between the recovered line timing and the local reference.
// Assumes both strobes are one-cycle pulses on clk; writes into a full buffer are dropped.
`default_nettype none
module scl_elastic_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic wr_en,
  input wire scl_pkg::scl_rx_t wr_data,
  output logic full,
  // Drain side
  input wire logic rd_en,
  output scl_pkg::scl_rx_t rd_data,
  output logic rd_valid
);
  scl_pkg::scl_rx_t mem [scl_pkg::EB_DEPTH];
  logic [scl_pkg::EB_AW:0] wr_ptr;
  logic [scl_pkg::EB_AW:0] rd_ptr;
  logic primed;
  wire [scl_pkg::EB_AW:0] fill = wr_ptr - rd_ptr;
  wire empty = (fill == '0);
  wire do_wr = wr_en && !full;
  wire do_rd = rd_en && primed && !empty;

  assign full = fill[scl_pkg::EB_AW];
  assign rd_data = mem[rd_ptr[scl_pkg::EB_AW-1:0]];
  assign rd_valid = do_rd;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[scl_pkg::EB_AW-1:0]] <= wr_data;
    end
  end

  // Reading waits for half a buffer so both clocks can drift either way
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      primed <= 1'b0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      if (fill >= scl_pkg::EB_START_FILL) primed <= 1'b1;
      else if (empty) primed <= 1'b0;
    end
  end
endmodule : scl_elastic_buf
`default_nettype wire

// >>> verilog/scl_config_top.sv
// Strap capture, reference clock selection, RMII timing and indicator drive.
// Assumes sys_rst is the power-on reset; every pin input is foreign to clk.
`default_nettype none
module scl_config_top #(
  parameter int unsigned BLINK_CYCLES = scl_pkg::BLINK_CYCLES_DEFAULT
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic sys_rst,
  // Hardware reset pin
  input wire logic hardware_reset_n,
  // Crystal or clock input, sampled as a link clock
  input wire logic crystal_or_clock_input,
  // Link indicator pin shared with the regulator strap
  input wire logic link_activity_indicator_i,
  output logic link_activity_indicator_o,
  output logic link_activity_indicator_oe,
  // Speed indicator pin shared with the clock-mode strap
  input wire logic speed_indicator_i,
  output logic speed_indicator_o,
  output logic speed_indicator_oe,
  // Shared interrupt or reference clock pin
  output logic shared_irq_clkout_pin_o,
  output logic shared_irq_clkout_pin_oe,
  // Latched configuration
  output logic regulator_enable,
  output logic irq_mode,
  output logic config_ready,
  // Internal status from the transceiver core
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic isolate,
  input wire logic irq_request,
  // RMII transmit from the MAC
  input wire scl_pkg::scl_tx_t rmii_tx,
  // Transmit toward the line
  output scl_pkg::scl_tx_t line_tx,
  // Receive from the line with its recovered clock
  input wire logic rx_recovered_clk,
  input wire scl_pkg::scl_rx_t line_rx,
  // RMII receive toward the MAC
  output scl_pkg::scl_rx_t rmii_rx
);
  function automatic logic [scl_pkg::HALF_W-1:0] half_of(
    input logic [scl_pkg::HALF_W-1:0] v
  );
    half_of = {1'b0, v[scl_pkg::HALF_W-1:1]};
  endfunction : half_of

  // Two-stage synchronisers for every pin input
  logic [1:0] rst_sync;
  logic [1:0] xin_sync;
  logic [1:0] link_activity_indicator_sync;
  logic [1:0] speed_indicator_sync;
  logic [1:0] rxclk_sync;
  scl_pkg::scl_tx_t tx_meta;
  scl_pkg::scl_tx_t tx_sync;
  scl_pkg::scl_rx_t rx_meta;
  scl_pkg::scl_rx_t rx_sync;
  logic xin_d;
  logic rxclk_d;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_sync <= 2'h0;
      xin_sync <= 2'h0;
      link_activity_indicator_sync <= 2'h0;
      speed_indicator_sync <= 2'h0;
      rxclk_sync <= 2'h0;
      tx_meta <= '0;
      tx_sync <= '0;
      rx_meta <= '0;
      rx_sync <= '0;
      xin_d <= 1'b0;
      rxclk_d <= 1'b0;
    end else begin
      rst_sync <= {rst_sync[0], hardware_reset_n};
      xin_sync <= {xin_sync[0], crystal_or_clock_input};
      link_activity_indicator_sync <= {link_activity_indicator_sync[0], link_activity_indicator_i};
      speed_indicator_sync <= {speed_indicator_sync[0], speed_indicator_i};
      rxclk_sync <= {rxclk_sync[0], rx_recovered_clk};
      tx_meta <= rmii_tx;
      tx_sync <= tx_meta;
      rx_meta <= line_rx;
      rx_sync <= rx_meta;
      xin_d <= xin_sync[1];
      rxclk_d <= rxclk_sync[1];
    end
  end

  wire hw_rst_n_s = rst_sync[1];
  wire xin_s = xin_sync[1];
  wire xin_edge = xin_s ^ xin_d;
  wire xin_rise = xin_s && !xin_d;
  wire rxclk_rise = rxclk_sync[1] && !rxclk_d;

  // Strap capture sequencer
  scl_pkg::scl_state_t state;
  scl_pkg::scl_state_t next_state;
  logic [1:0] settle;
  logic por_pending;
  logic sel_strap;
  logic reg_strap;

  wire settled = (settle == scl_pkg::SETTLE_CYCLES);
  wire running = (state == scl_pkg::SCL_ST_RUN);

  always_comb begin
    next_state = state;
    case (state)
      scl_pkg::SCL_ST_RESET: if (hw_rst_n_s) next_state = scl_pkg::SCL_ST_SAMPLE;
      scl_pkg::SCL_ST_SAMPLE: if (settled) next_state = scl_pkg::SCL_ST_RUN;
      scl_pkg::SCL_ST_RUN: if (!hw_rst_n_s) next_state = scl_pkg::SCL_ST_RESET;
      default: next_state = scl_pkg::SCL_ST_RESET;
    endcase
  end

  // Pins float during capture so the pull resistors set the strap level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= scl_pkg::SCL_ST_SAMPLE;
      settle <= 2'h0;
      por_pending <= 1'b1;
      sel_strap <= scl_pkg::SEL_STRAP_RESET;
      reg_strap <= scl_pkg::REG_STRAP_RESET;
    end else begin
      state <= next_state;
      settle <= (state == scl_pkg::SCL_ST_SAMPLE && !settled) ? settle + 2'h1 : 2'h0;
      if (state == scl_pkg::SCL_ST_SAMPLE && settled) begin
        sel_strap <= speed_indicator_sync[1];
        if (por_pending) begin
          reg_strap <= link_activity_indicator_sync[1];
          por_pending <= 1'b0;
        end
      end
    end
  end

  // Generated reference: toggles on each input edge and at mid interval, doubling the rate
  logic [scl_pkg::HALF_W-1:0] half_cnt;
  logic [scl_pkg::HALF_W-1:0] half_len;
  logic refo;
  wire mid_hit = (half_len >= scl_pkg::HALF_MIN) && (half_cnt == half_of(half_len));
  wire refo_toggle = xin_edge || mid_hit;
  // Clock-in mode times RMII from the input itself; a 50 MHz input would alias here
  wire ref_tick_c = sel_strap ? xin_rise : (refo_toggle && !refo);
  logic ref_tick;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_cnt <= '0;
      half_len <= '0;
      refo <= 1'b0;
      ref_tick <= 1'b0;
    end else begin
      if (xin_edge) begin
        half_len <= half_cnt;
        half_cnt <= '0;
      end else if (half_cnt != scl_pkg::HALF_MAX) begin
        half_cnt <= half_cnt + 1'b1;
      end
      if (refo_toggle) refo <= !refo;
      ref_tick <= ref_tick_c && running;
    end
  end

  // Receive path through the elasticity buffer
  scl_pkg::scl_rx_t eb_out;
  logic eb_valid;

  scl_elastic_buf u_eb (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(rxclk_rise && running),
    .wr_data(rx_sync),
    .full(),
    .rd_en(ref_tick),
    .rd_data(eb_out),
    .rd_valid(eb_valid)
  );

  // Transmit and receive registered on reference ticks, cleared on any cycle while not running or isolated
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_tx <= '0;
      rmii_rx <= '0;
    end else if (!running || isolate) begin
      line_tx <= '0;
      rmii_rx <= '0;
    end else if (ref_tick) begin
      line_tx <= tx_sync;
      rmii_rx <= eb_valid ? eb_out : '0;
    end
  end

  // Activity blink
  logic [scl_pkg::BLINK_W-1:0] blink_cnt;
  logic blink_phase;
  wire blink_wrap = (blink_cnt == scl_pkg::BLINK_W'(BLINK_CYCLES - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (!rmii_rx.dv) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt <= '0;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  wire link_active = link_up && !blink_phase;
  wire speed_active = speed_100 && !isolate;

  // Pin and status outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_activity_indicator_o <= 1'b0;
      link_activity_indicator_oe <= 1'b0;
      speed_indicator_o <= 1'b0;
      speed_indicator_oe <= 1'b0;
      shared_irq_clkout_pin_o <= 1'b0;
      shared_irq_clkout_pin_oe <= 1'b0;
      regulator_enable <= 1'b1;
      irq_mode <= 1'b1;
      config_ready <= 1'b0;
    end else begin
      link_activity_indicator_o <= link_active ^ reg_strap;
      link_activity_indicator_oe <= running;
      speed_indicator_o <= speed_active ^ sel_strap;
      speed_indicator_oe <= running;
      shared_irq_clkout_pin_o <= sel_strap ? !irq_request : refo;
      shared_irq_clkout_pin_oe <= running;
      regulator_enable <= !reg_strap;
      irq_mode <= sel_strap;
      config_ready <= running;
    end
  end
endmodule : scl_config_top
`default_nettype wire

// >>> dv/scl_config_properties.sv
// Port checker for the strap, clock and indicator block.
// Assumes straps are latched before config_ready rises; bound to scl_config_top.
`default_nettype none
module scl_config_properties (
  // Clock and resets
  input wire logic clk, sys_rst, hardware_reset_n,
  // Core status levels
  input wire logic link_up, speed_100, isolate, irq_request,
  // Pins and configuration
  input wire logic link_activity_indicator_o, link_activity_indicator_oe,
  input wire logic speed_indicator_o, speed_indicator_oe,
  input wire logic shared_irq_clkout_pin_o, shared_irq_clkout_pin_oe,
  input wire logic regulator_enable, irq_mode, config_ready,
  // Data paths
  input wire scl_pkg::scl_tx_t line_tx,
  input wire scl_pkg::scl_rx_t rmii_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Set once running, so a_reg_once checks that a later hardware reset does not re-sample the regulator strap
  logic seen_cfg;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) seen_cfg <= 1'b0;
    else if (config_ready) seen_cfg <= 1'b1;
  sequence s_hw_held; !hardware_reset_n [*5]; endsequence
  sequence s_running; config_ready && $past(config_ready); endsequence
  a_speed_pol: assert property (s_running |-> speed_indicator_o ==
    (($past(speed_100) && !$past(isolate)) ^ irq_mode))
    else $error("speed indicator level wrong");
  a_link_pol: assert property ((s_running and (!$past(rmii_rx.dv) && !$past(rmii_rx.dv, 2)))
    |-> link_activity_indicator_o == ($past(link_up) ^ !regulator_enable))
    else $error("link indicator level wrong");
  a_irq_out: assert property ((s_running and irq_mode) |->
    shared_irq_clkout_pin_o == !$past(irq_request)) else $error("irq output wrong");
  a_iso_tx: assert property (isolate |=> line_tx == '0) else $error("tx not blocked");
  a_iso_rx: assert property (isolate |=> rmii_rx == '0) else $error("rx not blocked");
  a_oe_run: assert property (shared_irq_clkout_pin_oe == config_ready &&
    link_activity_indicator_oe == config_ready && speed_indicator_oe == config_ready)
    else $error("pin enable wrong");
  a_hw_reset: assert property (s_hw_held |-> !config_ready)
    else $error("running in hardware reset");
  a_reg_once: assert property (seen_cfg |-> $stable(regulator_enable))
    else $error("regulator setting changed");
  a_mode_hold: assert property ($changed(irq_mode) |-> !$past(config_ready))
    else $error("clock mode changed while running");
endmodule : scl_config_properties
bind scl_config_top scl_config_properties u_chk (.clk, .sys_rst, .hardware_reset_n,
  .link_up, .speed_100, .isolate, .irq_request, .link_activity_indicator_o,
  .link_activity_indicator_oe, .speed_indicator_o, .speed_indicator_oe,
  .shared_irq_clkout_pin_o, .shared_irq_clkout_pin_oe, .regulator_enable, .irq_mode,
  .config_ready, .line_tx, .rmii_rx);
`default_nettype wire

// >>> dv/scl_mac_model.sv
// MAC side model: reference clock source and RMII transmit drive.
// Assumes the bench hands over the transmit value to send.
`default_nettype none
module scl_mac_model (
  // Reference clock toward the device
  output logic ref_clk,
  // Transmit value and pins
  input wire scl_pkg::scl_tx_t tx_val,
  output scl_pkg::scl_tx_t rmii_tx
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free running: the reference must never pause, even between frames
  initial begin
    ref_clk = 1'b0;
    forever #200 ref_clk = ~ref_clk;
  end
  // Launch on the falling reference edge, away from the sampling edge
  initial begin
    rmii_tx = '0;
    forever @(negedge ref_clk) rmii_tx <= tx_val;
  end
endmodule : scl_mac_model
`default_nettype wire

// >>> dv/scl_config_tb_top.sv
// Self-checking bench for scl_config_top with a MAC model.
// Assumes strap pulls: regulator pin down, clock-mode pin up, unless the bench overrides.
`default_nettype none
module scl_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, hw_n, ref_clk, rx_clk, link_up, speed_100, isolate, irq_req;
  logic reg_strap, sel_strap, link_o, link_oe, speed_o, speed_oe, shp_o, shp_oe;
  logic reg_en, irq_mode, ready;
  scl_pkg::scl_tx_t tx_val, rmii_tx, line_tx;
  scl_pkg::scl_rx_t line_rx, rmii_rx;
  int n_errors = 0, total_checks = 0, cyc = 0;
  wire logic link_pin = link_oe ? link_o : reg_strap;
  wire logic speed_pin = speed_oe ? speed_o : sel_strap;
  scl_config_top #(.BLINK_CYCLES(8)) uut (.clk(clk), .sys_rst(sys_rst),
    .hardware_reset_n(hw_n), .crystal_or_clock_input(ref_clk),
    .link_activity_indicator_i(link_pin), .link_activity_indicator_o(link_o),
    .link_activity_indicator_oe(link_oe), .speed_indicator_i(speed_pin),
    .speed_indicator_o(speed_o), .speed_indicator_oe(speed_oe),
    .shared_irq_clkout_pin_o(shp_o), .shared_irq_clkout_pin_oe(shp_oe),
    .regulator_enable(reg_en), .irq_mode(irq_mode), .config_ready(ready),
    .link_up(link_up), .speed_100(speed_100), .isolate(isolate), .irq_request(irq_req),
    .rmii_tx(rmii_tx), .line_tx(line_tx), .rx_recovered_clk(rx_clk), .line_rx(line_rx),
    .rmii_rx(rmii_rx));
  scl_mac_model mac (.ref_clk(ref_clk), .tx_val(tx_val), .rmii_tx(rmii_tx));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Recovered clock at the link rate but with its own phase
  initial begin
    rx_clk = 1'b0;
    #137;
    forever #200 rx_clk = ~rx_clk;
  end
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic exp_led(logic active, logic strap);
    return active ^ strap;
  endfunction : exp_led
  task automatic wait_ready();
    int i;
    for (i = 0; i < 40 && ready !== 1'b1; i++) @(negedge clk);
  endtask : wait_ready
  task automatic count_edges(output int n_link, output int n_clk);
    logic pl, pc;
    n_link = 0;
    n_clk = 0;
    pl = link_o;
    pc = shp_o;
    repeat (64) begin
      @(negedge clk);
      n_link += int'(link_o !== pl);
      n_clk += int'(shp_o !== pc);
      pl = link_o;
      pc = shp_o;
    end
  endtask : count_edges
  initial begin
    int i, nl, nc;
    logic [3:0] v;
    {sys_rst, hw_n, link_up, speed_100, isolate, irq_req} = 6'b110000;
    {reg_strap, sel_strap} = 2'b01;
    tx_val = '0;
    line_rx = '0;
    void'($urandom(32'h6492755c));
    // First pass keeps the pull defaults, then every other strap pairing
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      sys_rst = 1'b1;
      {reg_strap, sel_strap} = 2'(i) ^ 2'b01;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      wait_ready();
      chk("regulator_enable", {3'h0, !reg_strap}, {3'h0, reg_en});
      chk("irq_mode", {3'h0, sel_strap}, {3'h0, irq_mode});
      link_up = 1'($urandom);
      speed_100 = 1'($urandom);
      irq_req = 1'($urandom);
      repeat (2) @(negedge clk);
      chk("speed_indicator", {3'h0, exp_led(speed_100, sel_strap)}, {3'h0, speed_o});
      chk("link_indicator", {3'h0, exp_led(link_up, reg_strap)}, {3'h0, link_o});
      count_edges(nl, nc);
      if (sel_strap) chk("irq_out", {3'h0, !irq_req}, {3'h0, shp_o});
      else chk("clock_out_toggles", 4'h1, {3'h0, nc > 16});
      $display("Test strap pass %0d done", i);
    end
    {reg_strap, sel_strap} = 2'b01;
    hw_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("ready_in_reset", 4'h0, {3'h0, ready});
    hw_n = 1'b1;
    wait_ready();
    chk("irq_mode_resample", 4'h1, {3'h0, irq_mode});
    chk("regulator_kept", 4'h0, {3'h0, reg_en});
    $display("Test hardware reset done");
    for (i = 0; i < 6; i++) begin
      tx_val = (i == 0) ? 3'h7 : 3'($urandom);
      isolate = (i == 5);
      repeat (30) @(negedge clk);
      chk("line_tx", isolate ? 4'h0 : {1'b0, tx_val}, {1'b0, line_tx});
    end
    chk("speed_isolated", {3'h0, exp_led(1'b0, 1'b1)}, {3'h0, speed_o});
    $display("Test transmit done");
    isolate = 1'b0;
    link_up = 1'b1;
    v = 4'($urandom) | 4'h8;
    line_rx = v;
    repeat (60) @(negedge clk);
    chk("rmii_rx", v, rmii_rx);
    count_edges(nl, nc);
    chk("link_blinks", 4'h1, {3'h0, nl > 4});
    line_rx = '0;
    repeat (60) @(negedge clk);
    // Regulator strap stayed latched high from the last power-on
    chk("link_steady", {3'h0, exp_led(1'b1, 1'b1)}, {3'h0, link_o});
    $display("Test receive and blink done");
    stop_test();
  end
endmodule : scl_config_tb_top
`default_nettype wire
